// ==== dopwm_pkg.sv ====
/*
  Constants, field layout, bus state and carrier types of the
  dual output PWM timer.
  Assumes a 32-bit AHB-Lite bus and a single 100 MHz clock.
*/
package dopwm_pkg;

  // ****************************************
  // Register byte offsets
  // ****************************************
  localparam logic [7:0] OFS_PERIOD = 8'h00;
  localparam logic [7:0] OFS_RETURN_B = 8'h04;
  localparam logic [7:0] OFS_ACTIVE_A = 8'h08;
  localparam logic [7:0] OFS_ACTIVE_B = 8'h0C;
  localparam logic [7:0] OFS_PERIOD_BUF = 8'h10;
  localparam logic [7:0] OFS_RETURN_BUF = 8'h14;
  localparam logic [7:0] OFS_ACT_A_BUF = 8'h18;
  localparam logic [7:0] OFS_ACT_B_BUF = 8'h1C;
  localparam logic [7:0] OFS_PORT_LATCH = 8'h20;
  localparam logic [7:0] OFS_PORT_DIR = 8'h24;
  localparam logic [7:0] OFS_CONTROL = 8'h28;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h2C;
  localparam logic [7:0] OFS_IRQ_CLEAR = 8'h30;
  localparam logic [7:0] OFS_IRQ_ENABLE = 8'h34;
  localparam logic [7:0] OFS_COUNTER = 8'h38;

  // ****************************************
  // Control register fields
  // ****************************************
  localparam int CTL_START = 0;
  localparam int CTL_THREE_REGISTER_PWM_MODE = 1;
  localparam int CTL_CCLR_LO = 2;
  localparam int CTL_LVL_A = 5;
  localparam int CTL_LVL_B = 6;
  localparam int CTL_BF_C0 = 8;
  localparam int CTL_BF_D0 = 9;
  localparam int CTL_BF_C1 = 10;
  localparam int CTL_BF_D1 = 11;
  localparam int CTL_TCK_LO = 12;
  localparam logic [2:0] CCLR_ON_PERIOD = 3'h1;

  // ****************************************
  // Interrupt bits and pins
  // ****************************************
  localparam int IRQ_A = 0;
  localparam int IRQ_B = 1;
  localparam int IRQ_C = 2;
  localparam int IRQ_D = 3;
  localparam int IRQ_OVF = 4;
  localparam int IRQ_W = 5;
  localparam int PIN_FIRST = 7;
  localparam int PIN_SECOND = 5;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [15:0] RST_PERIOD = 16'hFFFF;
  localparam logic [15:0] RST_CMP = 16'h0000;
  localparam logic [15:0] RST_CONTROL = 16'h0000;
  localparam logic [7:0] RST_PORT_DIR = 8'hFF;
  localparam logic [7:0] RST_PORT_LATCH = 8'h00;
  localparam logic [4:0] RST_PRESCALE = 5'h00;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_WR = 4'b0010,
    ST_RD = 4'b0100,
    ST_RDY = 4'b1000
  } dopwm_state_type;

  typedef struct packed {
    logic [7:0] addr;
    logic write;
  } dopwm_aphase_type;

endpackage : dopwm_pkg

// ==== dopwm_top.sv ====
/*
  Dual output PWM timer: 16-bit counter, period and edge compares,
  buffered next-period values, port direction and latch, and
  maskable interrupt, behind an AHB-Lite slave.
  Assumes one clock, all inputs synchronous to it.
*/
// Decided for this implementation: the AHB-Lite register port and the register offsets.

// What this block does
// R1 - The overflow interrupt is raised from the overflow flag only while its enable bit is 1.
// R2 - Enable bit 3 lets a set match-D flag request an interrupt, else none.
// R3 - Enable bit 2 lets a set match-C flag request an interrupt, else none.
// R4 - Enable bit 1 lets a set match-B flag request an interrupt, else none.
// R5 - Enable bit 0 lets a set match-A flag request an interrupt, else none.
// R6 - The 16-bit period register takes any value and sets the period of both pins.
// R7 - The first-pin active point sets when that pin goes active, kept at most the period.
// R8 - The second-pin active point sets when that pin goes active, kept at most its return point.
// R9 - The second-pin return point sends that pin back, kept between its active point and period.
// R10 - With its select bit at 1 each buffer holds the next-period value of its compare.
// R11 - With its select bit at 0 a buffer has no effect on either pin.
// R12 - Software loads the buffers in the same order as the active compares.
// R13 - A direction bit of 0 drives the pin, 1 turns the driver off for input.
// R14 - With clear select 001 the counter clears on a period match and repeats.
// R15 - Level select 0 starts a pin low, high on its active match, low on its return match.
// R16 - Buffer values are copied into the compares at the period match.
module dopwm_top
  import dopwm_pkg::*;
(
  // Clock, reset, freeze
  input wire logic CLK,
  input wire logic RST,
  input wire logic CE,
  // AHB-Lite slave
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  // Port pins
  input wire logic [7:0] PORT_IN,
  output logic [7:0] PORT_OUT,
  output logic [7:0] PORT_OE,
  // Interrupt
  output logic IRQ
);

  // ****************************************
  // Functions
  // ****************************************
  function automatic logic [31:0] zext16(input logic [15:0] v);
    zext16 = {16'h0000, v};
  endfunction : zext16

  function automatic logic [31:0] zext8(input logic [7:0] v);
    zext8 = {24'h0000_00, v};
  endfunction : zext8

  function automatic logic [4:0] tck_mask(input logic [2:0] sel);
    case (sel)
      3'h1: tck_mask = 5'h01;
      3'h2: tck_mask = 5'h03;
      3'h3: tck_mask = 5'h07;
      3'h4: tck_mask = 5'h1F;
      default: tck_mask = 5'h00;
    endcase
  endfunction : tck_mask

  // ****************************************
  // Storage
  // ****************************************
  dopwm_state_type state_reg;
  dopwm_state_type state_next;
  dopwm_aphase_type aph_reg;
  logic [31:0] hrdata_reg;
  logic [15:0] period_reg;
  logic [15:0] ret_b_reg;
  logic [15:0] act_a_reg;
  logic [15:0] act_b_reg;
  logic [15:0] period_buf_reg;
  logic [15:0] ret_buf_reg;
  logic [15:0] act_a_buf_reg;
  logic [15:0] act_b_buf_reg;
  logic [7:0] latch_reg;
  logic [7:0] dir_reg;
  logic [15:0] ctl_reg;
  logic [IRQ_W-1:0] stat_reg;
  logic [IRQ_W-1:0] ien_reg;
  logic [15:0] cnt_reg;
  logic [15:0] cnt_next;
  logic [4:0] pre_reg;
  logic act_a_reg_q;
  logic act_b_reg_q;
  logic [7:0] port_out_reg;

  // ****************************************
  // Bus decode
  // ****************************************
  wire take = HSEL & HTRANS[1] & HREADY;
  wire wr_go = (state_reg == ST_WR) & aph_reg.write;
  wire [7:0] wa = aph_reg.addr;
  wire [15:0] wd16 = HWDATA[15:0];
  wire [7:0] wd8 = HWDATA[7:0];
  wire wr_period = wr_go & (wa == OFS_PERIOD);
  wire wr_ret_b = wr_go & (wa == OFS_RETURN_B);
  wire wr_act_a = wr_go & (wa == OFS_ACTIVE_A);
  wire wr_act_b = wr_go & (wa == OFS_ACTIVE_B);
  wire wr_pbuf = wr_go & (wa == OFS_PERIOD_BUF);
  wire wr_rbuf = wr_go & (wa == OFS_RETURN_BUF);
  wire wr_abuf = wr_go & (wa == OFS_ACT_A_BUF);
  wire wr_bbuf = wr_go & (wa == OFS_ACT_B_BUF);
  wire wr_latch = wr_go & (wa == OFS_PORT_LATCH);
  wire wr_dir = wr_go & (wa == OFS_PORT_DIR);
  wire wr_ctl = wr_go & (wa == OFS_CONTROL);
  wire wr_clr = wr_go & (wa == OFS_IRQ_CLEAR);
  wire wr_ien = wr_go & (wa == OFS_IRQ_ENABLE);
  wire wr_cnt = wr_go & (wa == OFS_COUNTER);

  // ****************************************
  // Read mux
  // ****************************************
  wire [7:0] ra = aph_reg.addr;
  wire [7:0] port_view = (latch_reg & ~dir_reg) | (PORT_IN & dir_reg);
  wire [31:0] rd_word =
    (ra == OFS_PERIOD) ? zext16(period_reg) :
    (ra == OFS_RETURN_B) ? zext16(ret_b_reg) :
    (ra == OFS_ACTIVE_A) ? zext16(act_a_reg) :
    (ra == OFS_ACTIVE_B) ? zext16(act_b_reg) :
    (ra == OFS_PERIOD_BUF) ? zext16(period_buf_reg) :
    (ra == OFS_RETURN_BUF) ? zext16(ret_buf_reg) :
    (ra == OFS_ACT_A_BUF) ? zext16(act_a_buf_reg) :
    (ra == OFS_ACT_B_BUF) ? zext16(act_b_buf_reg) :
    (ra == OFS_PORT_LATCH) ? zext8(port_view) :
    (ra == OFS_PORT_DIR) ? zext8(dir_reg) :
    (ra == OFS_CONTROL) ? zext16(ctl_reg) :
    (ra == OFS_IRQ_STATUS) ? zext8({3'h0, stat_reg}) :
    (ra == OFS_IRQ_ENABLE) ? zext8({3'h0, ien_reg}) :
    (ra == OFS_COUNTER) ? zext16(cnt_reg) :
    32'h0000_0000;

  // ****************************************
  // Bus state machine
  // ****************************************
  // Reads cost one wait state, writes none
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE, ST_WR, ST_RDY: begin
        if (take) begin
          state_next = HWRITE ? ST_WR : ST_RD;
        end else begin
          state_next = ST_IDLE;
        end
      end
      ST_RD: begin
        state_next = ST_RDY;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      state_reg <= ST_IDLE;
      aph_reg <= '0;
      hrdata_reg <= 32'h0000_0000;
    end else if (CE) begin
      state_reg <= state_next;
      if (take && state_reg != ST_RD) begin
        aph_reg <= '{addr: HADDR[7:0], write: HWRITE};
      end
      if (state_reg == ST_RD) begin
        hrdata_reg <= rd_word;
      end
    end
  end

  assign HRDATA = hrdata_reg;
  assign HREADYOUT = CE & (state_reg != ST_RD);
  assign HRESP = 1'b0;

  // ****************************************
  // Control fields
  // ****************************************
  wire run = ctl_reg[CTL_START];
  wire three_register_pwm_mode = ctl_reg[CTL_THREE_REGISTER_PWM_MODE];
  wire [2:0] cclr = ctl_reg[CTL_CCLR_LO +: 3];
  wire [2:0] tck = ctl_reg[CTL_TCK_LO +: 3];
  wire lvl_a = ctl_reg[CTL_LVL_A];
  wire lvl_b = ctl_reg[CTL_LVL_B];
  wire bf_c0 = ctl_reg[CTL_BF_C0];
  wire bf_d0 = ctl_reg[CTL_BF_D0];
  wire bf_c1 = ctl_reg[CTL_BF_C1];
  wire bf_d1 = ctl_reg[CTL_BF_D1];

  // ****************************************
  // Prescaler and counter
  // ****************************************
  wire [4:0] pmask = tck_mask(tck);
  wire tick = run & ((pre_reg & pmask) == pmask);
  wire m_period = tick & (cnt_reg == period_reg); // R6
  wire m_ret_b = tick & (cnt_reg == ret_b_reg);
  wire m_act_a = tick & (cnt_reg == act_a_reg);
  wire m_act_b = tick & (cnt_reg == act_b_reg);
  wire m_c = tick & (cnt_reg == period_buf_reg);
  wire m_d = tick & (cnt_reg == ret_buf_reg);
  wire clr_hit = m_period & (cclr == CCLR_ON_PERIOD); // R14
  wire ovf_hit = tick & ~clr_hit & (cnt_reg == 16'hFFFF);
  wire xfer = m_period; // R16

  // Copies stay idle while a select bit is 0
  wire cp_period = xfer & bf_c0; // R10 R11
  wire cp_ret_b = xfer & bf_d0; // R10 R11
  wire cp_act_a = xfer & bf_c1; // R10 R11
  wire cp_act_b = xfer & bf_d1; // R10 R11

  always_comb begin
    cnt_next = cnt_reg;
    if (wr_cnt) begin
      cnt_next = wd16;
    end else if (clr_hit) begin
      cnt_next = 16'h0000; // R14
    end else if (tick) begin
      cnt_next = cnt_reg + 16'h0001;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      cnt_reg <= RST_CMP;
      pre_reg <= RST_PRESCALE;
    end else if (CE) begin
      cnt_reg <= cnt_next;
      pre_reg <= run ? pre_reg + 5'h01 : RST_PRESCALE;
    end
  end

  // ****************************************
  // Compare and buffer registers
  // ****************************************
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      period_reg <= RST_PERIOD;
      ret_b_reg <= RST_CMP;
      act_a_reg <= RST_CMP;
      act_b_reg <= RST_CMP;
    end else if (CE) begin
      if (wr_period) begin
        period_reg <= wd16; // R6
      end else if (cp_period) begin
        period_reg <= period_buf_reg; // R10
      end
      if (wr_ret_b) begin
        ret_b_reg <= wd16; // R9
      end else if (cp_ret_b) begin
        ret_b_reg <= ret_buf_reg; // R10
      end
      if (wr_act_a) begin
        act_a_reg <= wd16; // R7
      end else if (cp_act_a) begin
        act_a_reg <= act_a_buf_reg; // R10
      end
      if (wr_act_b) begin
        act_b_reg <= wd16; // R8
      end else if (cp_act_b) begin
        act_b_reg <= act_b_buf_reg; // R10
      end
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      period_buf_reg <= RST_CMP;
      ret_buf_reg <= RST_CMP;
      act_a_buf_reg <= RST_CMP;
      act_b_buf_reg <= RST_CMP;
    end else if (CE) begin
      if (wr_pbuf) period_buf_reg <= wd16;
      if (wr_rbuf) ret_buf_reg <= wd16;
      if (wr_abuf) act_a_buf_reg <= wd16;
      if (wr_bbuf) act_b_buf_reg <= wd16;
    end
  end

  // ****************************************
  // Control, port and enable registers
  // ****************************************
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      ctl_reg <= RST_CONTROL;
      latch_reg <= RST_PORT_LATCH;
      dir_reg <= RST_PORT_DIR;
      ien_reg <= '0;
    end else if (CE) begin
      if (wr_ctl) ctl_reg <= wd16;
      if (wr_latch) latch_reg <= wd8;
      if (wr_dir) dir_reg <= wd8;
      if (wr_ien) ien_reg <= HWDATA[IRQ_W-1:0];
    end
  end

  // ****************************************
  // PWM edges
  // ****************************************
  // Return match wins when both edges coincide
  wire act_a_next = m_period ? 1'b0 : (m_act_a ? 1'b1 : act_a_reg_q); // R7 R15
  wire act_b_next = m_ret_b ? 1'b0 : (m_act_b ? 1'b1 : act_b_reg_q); // R8 R9
  wire pin_a = act_a_reg_q ^ lvl_a; // R15
  wire pin_b = act_b_reg_q ^ lvl_b;

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      act_a_reg_q <= 1'b0;
      act_b_reg_q <= 1'b0;
    end else if (CE) begin
      if (!run) begin
        act_a_reg_q <= 1'b0;
        act_b_reg_q <= 1'b0;
      end else begin
        act_a_reg_q <= act_a_next;
        act_b_reg_q <= act_b_next;
      end
    end
  end

  // ****************************************
  // Port output
  // ****************************************
  wire [7:0] pin_mux = three_register_pwm_mode ?
    {pin_a, latch_reg[6], pin_b, latch_reg[4:0]} : latch_reg;

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      port_out_reg <= RST_PORT_LATCH;
    end else if (CE) begin
      port_out_reg <= pin_mux;
    end
  end

  assign PORT_OUT = port_out_reg;
  assign PORT_OE = ~dir_reg; // R13

  // ****************************************
  // Interrupt status
  // ****************************************
  // Set wins over a clear in the same cycle
  wire [IRQ_W-1:0] ev = {ovf_hit, m_d, m_c, m_ret_b, m_period};
  wire [IRQ_W-1:0] clr = wr_clr ? HWDATA[IRQ_W-1:0] : '0;

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      stat_reg <= '0;
    end else if (CE) begin
      stat_reg <= (stat_reg & ~clr) | ev;
    end
  end

  wire irq_ovf = stat_reg[IRQ_OVF] & ien_reg[IRQ_OVF]; // R1
  wire irq_d = stat_reg[IRQ_D] & ien_reg[IRQ_D]; // R2
  wire irq_c = stat_reg[IRQ_C] & ien_reg[IRQ_C]; // R3
  wire irq_b = stat_reg[IRQ_B] & ien_reg[IRQ_B]; // R4
  wire irq_a = stat_reg[IRQ_A] & ien_reg[IRQ_A]; // R5

  // Level output, high while any enabled status bit is set
  assign IRQ = irq_ovf | irq_d | irq_c | irq_b | irq_a;

endmodule : dopwm_top

// ==== dopwm_props.sv ====
/*
  Port checker for dopwm_top: bus timing, pin direction, idle levels,
  latch path and interrupt masking.
  Assumes HREADY tied to HREADYOUT.
*/
module dopwm_props
  import dopwm_pkg::*;
(
  // Clock and reset
  input wire logic CLK,
  input wire logic RST,
  input wire logic CE,
  // Bus
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  input wire logic HREADYOUT,
  input wire logic HRESP,
  // Pins and interrupt
  input wire logic [7:0] PORT_OUT,
  input wire logic [7:0] PORT_OE,
  input wire logic IRQ
);
  // ****
  // Register shadows
  // ****
  logic ap_v_reg;
  logic ap_w_reg;
  logic [7:0] ap_a_reg;
  logic [7:0] dir_reg;
  logic [7:0] lat_reg;
  logic [4:0] en_reg;
  logic [15:0] ctl_reg;
  wire take = HSEL & HTRANS[1] & HREADY & CE;
  wire wr = ap_v_reg & ap_w_reg & HREADYOUT;
  always_ff @(posedge CLK) begin
    if (HREADYOUT) begin
      ap_a_reg <= HADDR[7:0];
      ap_w_reg <= HWRITE;
    end
  end
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      ap_v_reg <= 1'b0;
      dir_reg <= RST_PORT_DIR;
      lat_reg <= RST_PORT_LATCH;
      en_reg <= 5'h0;
      ctl_reg <= RST_CONTROL;
    end else begin
      if (HREADYOUT) ap_v_reg <= take;
      if (wr && ap_a_reg == OFS_PORT_DIR) dir_reg <= HWDATA[7:0];
      if (wr && ap_a_reg == OFS_PORT_LATCH) lat_reg <= HWDATA[7:0];
      if (wr && ap_a_reg == OFS_IRQ_ENABLE) en_reg <= HWDATA[4:0];
      if (wr && ap_a_reg == OFS_CONTROL) ctl_reg <= HWDATA[15:0];
    end
  end
  // ****
  // Properties
  // ****
  default clocking @(posedge CLK);
  endclocking
  default disable iff (RST);
  sequence rd_wait_s;
    !HREADYOUT ##1 HREADYOUT;
  endsequence
  sequence idle_s;
    ctl_reg[CTL_THREE_REGISTER_PWM_MODE] && !ctl_reg[CTL_START] && ctl_reg == $past(ctl_reg)
      && ctl_reg == $past(ctl_reg, 2) && ctl_reg == $past(ctl_reg, 3);
  endsequence
  sequence latch_s;
    !ctl_reg[CTL_THREE_REGISTER_PWM_MODE] && !$past(ctl_reg[CTL_THREE_REGISTER_PWM_MODE]) && !$past(ctl_reg[CTL_THREE_REGISTER_PWM_MODE], 2)
      && lat_reg == $past(lat_reg) && lat_reg == $past(lat_reg, 2);
  endsequence
  rd_wait_a: assert property (take && !HWRITE |=> rd_wait_s)
    else $error("read wait wrong");
  wr_ready_a: assert property (take && HWRITE |=> HREADYOUT)
    else $error("write data phase not ready");
  resp_okay_a: assert property (HRESP == 1'b0)
    else $error("response not okay");
  oe_dir_a: assert property (PORT_OE == ~dir_reg)
    else $error("output enable differs from direction");
  irq_mask_a: assert property (en_reg == 5'h0 |-> !IRQ)
    else $error("interrupt with all sources disabled");
  pin_a_idle_a: assert property (idle_s |-> PORT_OUT[PIN_FIRST] == ctl_reg[CTL_LVL_A])
    else $error("first pin not at initial level");
  pin_b_idle_a: assert property (idle_s |-> PORT_OUT[PIN_SECOND] == ctl_reg[CTL_LVL_B])
    else $error("second pin not at initial level");
  latch_out_a: assert property (latch_s |-> PORT_OUT == lat_reg)
    else $error("port output differs from latch");
endmodule : dopwm_props

bind dopwm_top dopwm_props dopwm_props_i (
  .CLK(CLK), .RST(RST), .CE(CE), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
  .HWRITE(HWRITE), .HWDATA(HWDATA), .HREADY(HREADY), .HREADYOUT(HREADYOUT),
  .HRESP(HRESP), .PORT_OUT(PORT_OUT), .PORT_OE(PORT_OE), .IRQ(IRQ)
);

// ==== tb_top.sv ====
/*
  Self-checking bench for dopwm_top: registers, port, PWM duty,
  buffered compares and interrupts.
  Assumes dopwm_pkg and the bound checker are compiled first.
*/
module tb_top import dopwm_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic CLK = 1'b0;
  logic RST = 1'b1;
  logic CE = 1'b1;
  logic HSEL = 1'b0;
  logic HWRITE = 1'b0;
  logic [1:0] HTRANS = 2'h0;
  logic [2:0] HSIZE = 3'h2;
  logic [31:0] HADDR = 32'h0;
  logic [31:0] HWDATA = 32'h0;
  logic [7:0] PORT_IN = 8'h0;
  logic [31:0] HRDATA;
  logic [31:0] q;
  logic [7:0] PORT_OUT;
  logic [7:0] PORT_OE;
  logic HREADYOUT;
  logic HRESP;
  logic IRQ;
  int n_errors = 0;
  int checked = 0;
  int a;
  int b;
  always #5 CLK = ~CLK;
  dopwm_top dopwm_top_i (
    .CLK(CLK), .RST(RST), .CE(CE), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
    .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADYOUT),
    .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .PORT_IN(PORT_IN),
    .PORT_OUT(PORT_OUT), .PORT_OE(PORT_OE), .IRQ(IRQ)
  );
  // ****
  // Shared tasks
  // ****
  task summarize;
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : summarize
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task rdy;
    int n;
    n = 0;
    do begin
      @(posedge CLK);
      n++;
    end while (HREADYOUT !== 1'b1 && n < 100);
    if (HREADYOUT !== 1'b1) begin
      n_errors++;
      summarize();
    end
  endtask : rdy
  task xf(input logic w, input logic [7:0] ad, input logic [31:0] d);
    @(posedge CLK);
    HSEL <= 1'b1;
    HTRANS <= 2'h2;
    HWRITE <= w;
    HADDR <= {24'h0, ad};
    rdy();
    HSEL <= 1'b0;
    HTRANS <= 2'h0;
    HWDATA <= d;
    rdy();
    q = HRDATA;
  endtask : xf
  task wr(input logic [7:0] ad, input logic [31:0] d);
    xf(1'b1, ad, d);
  endtask : wr
  task rc(input string n, input logic [7:0] ad, input logic [31:0] e);
    xf(1'b0, ad, 32'h0);
    chk(n, e, q);
  endtask : rc
  task duty;
    repeat (30) @(posedge CLK);
    a = 0;
    b = 0;
    repeat (20) begin
      @(posedge CLK);
      a += (PORT_OUT[PIN_FIRST] === 1'b1);
      b += (PORT_OUT[PIN_SECOND] === 1'b1);
    end
  endtask : duty
  // ****
  // Scenarios
  // ****
  task t_regs;
    rc("period", OFS_PERIOD, 32'hFFFF);
    rc("dir", OFS_PORT_DIR, 32'hFF);
    chk("oe", 32'h0, 32'(PORT_OE));
    wr(OFS_PERIOD, 32'hFFFF_0000);
    rc("period lo", OFS_PERIOD, 32'h0);
    wr(8'h3C, 32'h1234);
    rc("unmapped", 8'h3C, 32'h0);
  endtask : t_regs
  task t_port;
    PORT_IN <= 8'h0F;
    wr(OFS_PORT_DIR, 32'h5F);
    #1;
    chk("oe", 32'hA0, 32'(PORT_OE));
    wr(OFS_PORT_LATCH, 32'hA0);
    rc("pin read", OFS_PORT_LATCH, 32'hAF);
    repeat (2) @(posedge CLK);
    #1;
    chk("latch out", 32'hA0, 32'(PORT_OUT));
  endtask : t_port
  task t_pwm;
    wr(OFS_PERIOD, 32'h9);
    wr(OFS_ACTIVE_A, 32'h3);
    wr(OFS_RETURN_B, 32'h6);
    wr(OFS_ACTIVE_B, 32'h2);
    wr(OFS_CONTROL, 32'h7);
    duty();
    chk("duty a", 32'hC, 32'(a));
    chk("duty b", 32'h8, 32'(b));
    for (int i = 0; i < 3; i++) begin
      xf(1'b0, OFS_COUNTER, 32'h0);
      chk("count", 32'h1, 32'(q < 32'hA));
    end
    wr(OFS_CONTROL, 32'h27);
    duty();
    chk("inv a", 32'h8, 32'(a));
  endtask : t_pwm
  task t_buf;
    wr(OFS_PERIOD_BUF, 32'h9);
    wr(OFS_RETURN_BUF, 32'h7);
    wr(OFS_ACT_A_BUF, 32'h5);
    wr(OFS_ACT_B_BUF, 32'h3);
    wr(OFS_CONTROL, 32'hF07);
    duty();
    chk("buf duty", 32'h8, 32'(a));
    chk("buf duty b", 32'h8, 32'(b));
    rc("copied", OFS_ACTIVE_A, 32'h5);
    rc("copied ret", OFS_RETURN_B, 32'h7);
    rc("copied act b", OFS_ACTIVE_B, 32'h3);
    rc("period kept", OFS_PERIOD, 32'h9);
    wr(OFS_CONTROL, 32'h7);
    wr(OFS_ACT_A_BUF, 32'h1);
    duty();
    chk("unbuf duty", 32'h8, 32'(a));
    rc("kept", OFS_ACTIVE_A, 32'h5);
  endtask : t_buf
  task t_freeze;
    repeat (4) @(posedge CLK);
    CE <= 1'b0;
    @(posedge CLK);
    q = 32'(PORT_OUT);
    repeat (15) @(posedge CLK);
    chk("frozen pins", q, 32'(PORT_OUT));
    chk("frozen ready", 32'h0, 32'(HREADYOUT));
    CE <= 1'b1;
  endtask : t_freeze
  task t_scale;
    for (int s = 1; s < 3; s++) begin
      wr(OFS_CONTROL, 32'h1 | (s << CTL_TCK_LO));
      xf(1'b0, OFS_COUNTER, 32'h0);
      b = q;
      xf(1'b0, OFS_COUNTER, 32'h0);
      chk("prescale", 32'(4 >> s), q - 32'(b));
    end
  endtask : t_scale
  task t_irq;
    chk("irq off", 32'h0, 32'(IRQ));
    wr(OFS_CONTROL, 32'h6);
    rc("status", OFS_IRQ_STATUS, 32'hF);
    for (int i = 0; i < 4; i++) begin
      wr(OFS_IRQ_ENABLE, 32'h1 << i);
      #1;
      chk("irq src", 32'h1, 32'(IRQ));
    end
    wr(OFS_IRQ_ENABLE, 32'h10);
    #1;
    chk("irq no ovf", 32'h0, 32'(IRQ));
    wr(OFS_IRQ_CLEAR, 32'h1F);
    rc("cleared", OFS_IRQ_STATUS, 32'h0);
    wr(OFS_CONTROL, 32'h2);
    wr(OFS_COUNTER, 32'hFFF0);
    wr(OFS_CONTROL, 32'h3);
    repeat (30) @(posedge CLK);
    #1;
    chk("irq ovf", 32'h1, 32'(IRQ));
    wr(OFS_IRQ_ENABLE, 32'h0);
    #1;
    chk("irq masked", 32'h0, 32'(IRQ));
  endtask : t_irq
  initial begin
    repeat (2) @(posedge CLK);
    RST <= 1'b0;
    t_regs();
    t_port();
    t_pwm();
    t_freeze();
    t_buf();
    t_scale();
    t_irq();
    summarize();
  end
endmodule : tb_top
